// ---- hw/cpr_pkg.sv ----
package cpr_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  CPR_ADDR_CURRENTS = 8'h09;
    localparam logic [7:0]  CPR_ADDR_BIAS     = 8'h0A;
    localparam logic [7:0]  CPR_ADDR_DETECTOR = 8'h0B;

    // values after reset
    localparam logic [23:0] CPR_RST_CURRENTS  = 24'h000000;
    localparam logic [1:0]  CPR_RST_BIAS      = 2'h0;
    localparam logic [11:0] CPR_RST_DETECTOR  = 12'h870;

    // ************************************************************
    // pump current register fields (lsb positions)
    // ************************************************************
    localparam int CPR_UP_OFFSET_LSB = 2;
    localparam int CPR_DN_OFFSET_LSB = 7;
    localparam int CPR_UP_TRIM_LSB   = 10;
    localparam int CPR_DN_TRIM_LSB   = 14;
    localparam int CPR_UP_MAIN_LSB   = 18;
    localparam int CPR_DN_MAIN_LSB   = 21;

    // ************************************************************
    // detector register fields
    // ************************************************************
    localparam int CPR_DELAY_LSB     = 0;
    localparam int CPR_SWAP_BIT      = 3;
    localparam int CPR_UP_GATE_BIT   = 4;
    localparam int CPR_DN_GATE_BIT   = 5;
    localparam int CPR_LOCK_OE_BIT   = 6;
    localparam int CPR_FORCE_UP_BIT  = 7;
    localparam int CPR_FORCE_DN_BIT  = 8;
    localparam int CPR_MUTE_BIT      = 9;

    // ************************************************************
    // current steps in microamps
    // ************************************************************
    localparam logic [10:0] CPR_OFFSET_STEP_UA = 11'h037;
    localparam logic [10:0] CPR_TRIM_STEP_UA   = 11'h007;
    localparam logic [10:0] CPR_MAIN_STEP_UA   = 11'h1F4;
    localparam logic [2:0]  CPR_MAIN_SAT_CODE  = 3'h4;
    localparam logic [10:0] CPR_BIAS_UA_0      = 11'h21C;
    localparam logic [10:0] CPR_BIAS_UA_1      = 11'h2B1;
    localparam logic [10:0] CPR_BIAS_UA_2      = 11'h3AF;
    localparam logic [10:0] CPR_BIAS_UA_3      = 11'h5DF;

    // consecutive in-window edges needed for lock
    localparam logic [9:0]  CPR_LOCK_COUNT_DEFAULT = 10'h0FA;

endpackage

// ---- hw/cpr_lock_detect.sv ----
`timescale 1ns/10ps
module cpr_lock_detect
    import cpr_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // window samples
    input  wire logic       vco_edge_i,
    input  wire logic       in_window_i,
    input  wire logic [9:0] lock_count_i,
    // lock state
    output logic            locked_o
);

    typedef struct packed {
        logic [9:0] count;
        logic       locked;
    } cpr_lock_t;

    cpr_lock_t st;
    cpr_lock_t next_st;
    logic [9:0] bumped;

    // ************************************************************
    // consecutive window counter
    // ************************************************************
    // lock after consecutive count
    always_comb begin
        next_st = st;
        bumped  = (st.count == 10'h3FF) ? st.count : st.count + 10'h001;
        if (vco_edge_i) begin
            if (in_window_i) begin
                next_st.count = bumped;
                // a zero threshold still needs one good edge
                if (bumped >= lock_count_i) begin
                    next_st.locked = 1'b1;
                end
            end else begin
                next_st.count  = 10'h000;
                next_st.locked = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign locked_o = st.locked;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_lock_rise_cause: assert property (
        $rose(locked_o) |-> $past(vco_edge_i && in_window_i)
            && ($past(bumped) >= $past(lock_count_i)))
        else $error("lock declared without enough good edges");
    a_lock_miss_drop: assert property (
        (vco_edge_i && !in_window_i) |=> !locked_o)
        else $error("lock kept after an out-of-window edge");

endmodule

// ---- hw/cpr_regs.sv ----
`timescale 1ns/10ps
// What this block does
// - up offset code gives 55 uA steps
// - down offset code gives 55 uA steps
// - up trim code gives 7 uA steps
// - down trim code gives 7 uA steps
// - main codes 500 uA steps, saturate; code 0 tristates while detector disabled
// - bias code selects current, gated by enable
// - swap bit exchanges detector inputs
// - up and down gates enable detector outputs
// - lock flag routed to shared pin
// - force bit holds up output active
// - force bit holds down output active
// - mute mode gates only while locked
// - without mute, gates apply always
// - lock after programmable consecutive in-window edges
module cpr_regs
    import cpr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // register port from the serial interface
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [23:0] wr_data_i,
    output logic [23:0]      rd_data_o,
    output logic             rd_valid_o,
    // neighbouring controls and lock window
    input  wire logic        pump_enable_i,
    input  wire logic        detector_enable_i,
    input  wire logic        vco_edge_i,
    input  wire logic        in_window_i,
    input  wire logic [9:0]  lock_count_i,
    // detector core
    input  wire logic        ref_in_i,
    input  wire logic        div_in_i,
    input  wire logic        raw_up_i,
    input  wire logic        raw_down_i,
    output logic             det_first_o,
    output logic             det_second_o,
    output logic             det_up_o,
    output logic             det_down_o,
    output logic [2:0]       reset_delay_code_o,
    // shared lock / serial data pin
    input  wire logic        serial_data_i,
    output logic             lock_serial_out_pin_o,
    output logic             locked_o,
    // pump currents in microamps
    output logic [10:0]      up_offset_ua_o,
    output logic [10:0]      down_offset_ua_o,
    output logic [10:0]      up_trim_ua_o,
    output logic [10:0]      down_trim_ua_o,
    output logic [10:0]      up_main_ua_o,
    output logic [10:0]      down_main_ua_o,
    output logic             up_pump_tristate_o,
    output logic             down_pump_tristate_o,
    output logic [10:0]      pump_amp_bias_ua_o
);

    typedef struct packed {
        logic [23:0] charge_pump_currents;
        logic [1:0]  charge_pump_opamp_bias;
        logic [11:0] phase_detector_control;
        logic [23:0] rd_data;
        logic        rd_valid;
    } cpr_state_t;

    cpr_state_t st;
    cpr_state_t next_st;
    logic [1:0] rst_pipe;
    logic       rst_sync_n;
    logic       up_gate_ok;
    logic       down_gate_ok;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic [10:0] cpr_step3(input logic [2:0] code,
                                              input logic [10:0] step);
        cpr_step3 = 11'(code * step);
    endfunction
    function automatic logic [10:0] cpr_trim(input logic [3:0] code);
        cpr_trim = 11'(code * CPR_TRIM_STEP_UA);
    endfunction
    // codes at and above the saturation code all give the top current
    function automatic logic [10:0] cpr_main(input logic [2:0] code);
        cpr_main = cpr_step3((code >= CPR_MAIN_SAT_CODE)
                             ? CPR_MAIN_SAT_CODE : code, CPR_MAIN_STEP_UA);
    endfunction

    // ************************************************************
    // reset release
    // ************************************************************
    // two flops so release never lands mid-cycle in the logic
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ************************************************************
    // register file
    // ************************************************************
    // hold until rewritten
    // reserved pump bits are stored as written; software keeps them 0
    always_comb begin
        next_st          = st;
        next_st.rd_valid = rd_en_i;
        if (wr_en_i) begin
            unique case (addr_i)
                CPR_ADDR_CURRENTS: next_st.charge_pump_currents = wr_data_i;
                CPR_ADDR_BIAS:     next_st.charge_pump_opamp_bias =
                                       wr_data_i[1:0];
                CPR_ADDR_DETECTOR: next_st.phase_detector_control =
                                       wr_data_i[11:0];
                default: ;  // unmapped writes are dropped
            endcase
        end
        if (rd_en_i) begin
            unique case (addr_i)
                CPR_ADDR_CURRENTS: next_st.rd_data = st.charge_pump_currents;
                CPR_ADDR_BIAS:     next_st.rd_data =
                                       {22'h0, st.charge_pump_opamp_bias};
                CPR_ADDR_DETECTOR: next_st.rd_data =
                                       {12'h000, st.phase_detector_control};
                default:           next_st.rd_data = 24'h000000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st.charge_pump_currents   <= CPR_RST_CURRENTS;
            st.charge_pump_opamp_bias <= CPR_RST_BIAS;
            st.phase_detector_control <= CPR_RST_DETECTOR;
            st.rd_data                <= 24'h000000;
            st.rd_valid               <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data_o  = st.rd_data;
    assign rd_valid_o = st.rd_valid;

    // ************************************************************
    // lock detection
    // ************************************************************
    // lock state source
    cpr_lock_detect u_lock (
        .clk_i        (clk_i),
        .rst_n_i      (rst_sync_n),
        .vco_edge_i   (vco_edge_i),
        .in_window_i  (in_window_i),
        .lock_count_i (lock_count_i),
        .locked_o     (locked_o)
    );

    // ************************************************************
    // pump current decode
    // ************************************************************
    // up offset decode
    assign up_offset_ua_o = cpr_step3(
        st.charge_pump_currents[CPR_UP_OFFSET_LSB +: 3], CPR_OFFSET_STEP_UA);
    assign down_offset_ua_o = cpr_step3(
        st.charge_pump_currents[CPR_DN_OFFSET_LSB +: 3], CPR_OFFSET_STEP_UA);
    assign up_trim_ua_o = cpr_trim(
        st.charge_pump_currents[CPR_UP_TRIM_LSB +: 4]);
    assign down_trim_ua_o = cpr_trim(
        st.charge_pump_currents[CPR_DN_TRIM_LSB +: 4]);
    assign up_main_ua_o = cpr_main(
        st.charge_pump_currents[CPR_UP_MAIN_LSB +: 3]);
    assign down_main_ua_o = cpr_main(
        st.charge_pump_currents[CPR_DN_MAIN_LSB +: 3]);
    assign up_pump_tristate_o = !detector_enable_i
        && (st.charge_pump_currents[CPR_UP_MAIN_LSB +: 3] == 3'h0);
    assign down_pump_tristate_o = !detector_enable_i
        && (st.charge_pump_currents[CPR_DN_MAIN_LSB +: 3] == 3'h0);
    always_comb begin
        pump_amp_bias_ua_o = 11'h000;
        if (pump_enable_i) begin
            unique case (st.charge_pump_opamp_bias)
                2'h0: pump_amp_bias_ua_o = CPR_BIAS_UA_0;
                2'h1: pump_amp_bias_ua_o = CPR_BIAS_UA_1;
                2'h2: pump_amp_bias_ua_o = CPR_BIAS_UA_2;
                2'h3: pump_amp_bias_ua_o = CPR_BIAS_UA_3;
            endcase
        end
    end

    // ************************************************************
    // detector steering
    // ************************************************************
    // delay code passed through; zero in integer mode is the user's risk
    assign reset_delay_code_o =
        st.phase_detector_control[CPR_DELAY_LSB +: 3];
    assign det_first_o  = st.phase_detector_control[CPR_SWAP_BIT]
                          ? div_in_i : ref_in_i;
    assign det_second_o = st.phase_detector_control[CPR_SWAP_BIT]
                          ? ref_in_i : div_in_i;
    assign up_gate_ok = st.phase_detector_control[CPR_UP_GATE_BIT]
        || (st.phase_detector_control[CPR_MUTE_BIT] && !locked_o);
    assign down_gate_ok = st.phase_detector_control[CPR_DN_GATE_BIT]
        || (st.phase_detector_control[CPR_MUTE_BIT] && !locked_o);
    // force up and down
    // gating is kept combinational so pump pulses see no added delay
    assign det_up_o   = st.phase_detector_control[CPR_FORCE_UP_BIT]
                        || (raw_up_i && up_gate_ok);
    assign det_down_o = st.phase_detector_control[CPR_FORCE_DN_BIT]
                        || (raw_down_i && down_gate_ok);

    assign lock_serial_out_pin_o = st.phase_detector_control[CPR_LOCK_OE_BIT]
                                   ? locked_o : serial_data_i;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_sync_n);

    a_up_offset_step: assert property (
        up_offset_ua_o == 11'(st.charge_pump_currents[4:2] * 55))
        else $error("up offset current wrong");
    a_dn_offset_step: assert property (
        down_offset_ua_o == 11'(st.charge_pump_currents[9:7] * 55))
        else $error("down offset current wrong");
    a_trim_steps: assert property (
        up_trim_ua_o == 11'(st.charge_pump_currents[13:10] * 7))
        else $error("up trim current wrong");
    a_dn_trim_steps: assert property (
        down_trim_ua_o == 11'(st.charge_pump_currents[17:14] * 7))
        else $error("down trim current wrong");
    a_main_saturate: assert property (
        (!st.charge_pump_currents[20] || up_main_ua_o == 11'h7D0)
        && (!st.charge_pump_currents[23] || down_main_ua_o == 11'h7D0))
        else $error("main current not saturated");
    a_bias_gated_off: assert property (
        !pump_enable_i |-> pump_amp_bias_ua_o == 11'h000)
        else $error("bias active without pump enable");
    a_swap_inputs: assert property (
        st.phase_detector_control[3] |-> det_first_o == div_in_i
                                      && det_second_o == ref_in_i)
        else $error("detector inputs not swapped");
    a_gate_no_mute: assert property (
        (!st.phase_detector_control[9] && !st.phase_detector_control[7]
         && !st.phase_detector_control[4]) |-> !det_up_o)
        else $error("up output passed while gated");
    a_mute_unlocked: assert property (
        (st.phase_detector_control[9] && !locked_o
         && !st.phase_detector_control[8]) |-> det_down_o == raw_down_i)
        else $error("down output gated while unlocked");
    a_lock_pin_route: assert property (
        st.phase_detector_control[6] |-> lock_serial_out_pin_o == locked_o)
        else $error("lock flag not on shared pin");
    a_force_up_on: assert property (
        st.phase_detector_control[7] |-> det_up_o)
        else $error("forced up output inactive");
    a_force_dn_on: assert property (
        st.phase_detector_control[8] |-> det_down_o)
        else $error("forced down output inactive");
    a_write_holds: assert property (
        (wr_en_i && addr_i == CPR_ADDR_DETECTOR) |=>
            st.phase_detector_control == $past(wr_data_i[11:0]))
        else $error("detector register lost its value");
    a_idle_holds: assert property (
        !wr_en_i |=> $stable(st.phase_detector_control))
        else $error("detector register changed without a write");

    c_mute_locked: cover property (
        st.phase_detector_control[9] && locked_o && raw_up_i);
    c_swap_set: cover property (st.phase_detector_control[3]);
    c_read_back: cover property (rd_en_i ##1 rd_valid_o);
    c_main_tristate: cover property (up_pump_tristate_o);

endmodule

// ---- test/cpr_regs_test.sv ----
`timescale 1ns/10ps
module cpr_regs_test
    import cpr_pkg::*;
;
    // ****************************************************************
    // bench signals
    // ****************************************************************
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        wr_en_i = 1'b0;
    logic        rd_en_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [23:0] wr_data_i = 24'h000000;
    logic        pump_enable_i = 1'b1;
    logic        detector_enable_i = 1'b0;
    logic        vco_edge_i = 1'b0;
    logic        in_window_i = 1'b0;
    logic [9:0]  lock_count_i = 10'h003;
    logic        ref_in_i = 1'b1;
    logic        div_in_i = 1'b0;
    logic        raw_up_i = 1'b1;
    logic        raw_down_i = 1'b0;
    logic        serial_data_i = 1'b1;
    logic [23:0] rd_data_o;
    logic        rd_valid_o;
    logic        det_first_o;
    logic        det_second_o;
    logic        det_up_o;
    logic        det_down_o;
    logic [2:0]  reset_delay_code_o;
    logic        lock_serial_out_pin_o;
    logic        locked_o;
    logic [10:0] up_offset_ua_o;
    logic [10:0] down_offset_ua_o;
    logic [10:0] up_trim_ua_o;
    logic [10:0] down_trim_ua_o;
    logic [10:0] up_main_ua_o;
    logic [10:0] down_main_ua_o;
    logic        up_pump_tristate_o;
    logic        down_pump_tristate_o;
    logic [10:0] pump_amp_bias_ua_o;
    int          failures = 0;
    int          n_tests = 0;

    cpr_regs dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .pump_enable_i(pump_enable_i),
        .detector_enable_i(detector_enable_i), .vco_edge_i(vco_edge_i),
        .in_window_i(in_window_i), .lock_count_i(lock_count_i),
        .ref_in_i(ref_in_i), .div_in_i(div_in_i), .raw_up_i(raw_up_i),
        .raw_down_i(raw_down_i), .det_first_o(det_first_o),
        .det_second_o(det_second_o), .det_up_o(det_up_o),
        .det_down_o(det_down_o), .reset_delay_code_o(reset_delay_code_o),
        .serial_data_i(serial_data_i),
        .lock_serial_out_pin_o(lock_serial_out_pin_o),
        .locked_o(locked_o), .up_offset_ua_o(up_offset_ua_o),
        .down_offset_ua_o(down_offset_ua_o), .up_trim_ua_o(up_trim_ua_o),
        .down_trim_ua_o(down_trim_ua_o), .up_main_ua_o(up_main_ua_o),
        .down_main_ua_o(down_main_ua_o),
        .up_pump_tristate_o(up_pump_tristate_o),
        .down_pump_tristate_o(down_pump_tristate_o),
        .pump_amp_bias_ua_o(pump_amp_bias_ua_o)
    );

    // 100 ns period
    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // write lands on the edge that samples the strobe
    task automatic reg_write(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk_i);
        wr_en_i   <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        #1;
    endtask

    // bounded wait on the read answer; a hang ends the run
    task automatic reg_read(input logic [7:0] a, output logic [23:0] q);
        int i;
        @(posedge clk_i);
        rd_en_i <= 1'b1;
        addr_i  <= a;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1;
        for (i = 0; i < 4 && rd_valid_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (rd_valid_o !== 1'b1) begin
            failures++;
            $display("ERROR at %0t: read answer missing", $time);
            report_and_stop();
        end
        q = rd_data_o;
    endtask

    // one divided-oscillator edge, in or out of the window
    task automatic vco_pulse(input logic win);
        @(posedge clk_i);
        vco_edge_i  <= 1'b1;
        in_window_i <= win;
        @(posedge clk_i);
        vco_edge_i <= 1'b0;
        #1;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_reset_values();
        logic [23:0] q;
        reg_read(8'h09, q);
        check(q, 24'h000000);
        reg_read(8'h0A, q);
        check(q, 24'h000000);
        reg_read(8'h0B, q);
        check(q, 24'h000870);
        check(24'(pump_amp_bias_ua_o), 24'd540);
        check(24'(lock_serial_out_pin_o), 24'h000000);
        check(24'(locked_o), 24'h000000);
        check({up_pump_tristate_o, down_pump_tristate_o}, 24'h000003);
    endtask

    // every offset and main code, odd and even trims, back to back
    task automatic test_pump_currents();
        logic [23:0] d;
        logic [23:0] q;
        logic [2:0]  a;
        logic [2:0]  b;
        logic [3:0]  t;
        logic [3:0]  u;
        for (int c = 0; c < 8; c++) begin
            a = 3'(c);
            b = 3'(7 - c);
            t = 4'(2 * c + 1);
            u = 4'(14 - 2 * c);
            d = {b, a, u, t, b, 2'b00, a, 2'b00};
            @(posedge clk_i);
            detector_enable_i <= a[0];
            reg_write(8'h09, d);
            check(24'(up_offset_ua_o), 24'(c * 55));
            check(24'(down_offset_ua_o), 24'((7 - c) * 55));
            check(24'(up_trim_ua_o), 24'(t * 7));
            check(24'(down_trim_ua_o), 24'(u * 7));
            check(24'(up_main_ua_o), 24'((c > 4 ? 4 : c) * 500));
            check(24'(down_main_ua_o), 24'((c < 3 ? 4 : 7 - c) * 500));
            check(24'(up_pump_tristate_o), 24'(c == 0));
            check(24'(down_pump_tristate_o), 24'(0));
            reg_read(8'h09, q);
            check(q, d);
        end
    endtask

    task automatic test_bias();
        int          tab [4] = '{540, 689, 943, 1503};
        logic [23:0] q;
        for (int b = 0; b < 4; b++) begin
            @(posedge clk_i);
            pump_enable_i <= 1'b1;
            reg_write(8'h0A, 24'(b));
            check(24'(pump_amp_bias_ua_o), 24'(tab[b]));
            @(posedge clk_i);
            pump_enable_i <= 1'b0;
            #1;
            check(24'(pump_amp_bias_ua_o), 24'h000000);
            reg_read(8'h0A, q);
            check(q, 24'(b));
        end
        @(posedge clk_i);
        pump_enable_i <= 1'b1;
    endtask

    task automatic test_detector();
        @(posedge clk_i);
        serial_data_i <= 1'b1;
        raw_up_i      <= 1'b1;
        raw_down_i    <= 1'b0;
        reg_write(8'h0B, 24'h000832);
        check(24'(reset_delay_code_o), 24'h000002);
        check({det_first_o, det_second_o}, 24'h000002);
        check({det_up_o, det_down_o}, 24'h000002);
        check(24'(lock_serial_out_pin_o), 24'h000001);
        reg_write(8'h0B, 24'h00083A);
        check({det_first_o, det_second_o}, 24'h000001);
        @(posedge clk_i);
        raw_down_i <= 1'b1;
        reg_write(8'h0B, 24'h000802);
        check({det_up_o, det_down_o}, 24'h000000);
        @(posedge clk_i);
        raw_up_i   <= 1'b0;
        raw_down_i <= 1'b0;
        reg_write(8'h0B, 24'h000882);
        check({det_up_o, det_down_o}, 24'h000002);
        reg_write(8'h0B, 24'h000902);
        check({det_up_o, det_down_o}, 24'h000001);
    endtask

    task automatic test_mute_lock();
        @(posedge clk_i);
        serial_data_i <= 1'b0;
        raw_up_i      <= 1'b1;
        raw_down_i    <= 1'b1;
        reg_write(8'h0B, 24'h000A62);
        check({det_up_o, det_down_o}, 24'h000003);
        check(24'(lock_serial_out_pin_o), 24'h000000);
        vco_pulse(1'b1);
        vco_pulse(1'b1);
        check(24'(locked_o), 24'h000000);
        vco_pulse(1'b1);
        check(24'(locked_o), 24'h000001);
        check({det_up_o, det_down_o}, 24'h000001);
        check(24'(lock_serial_out_pin_o), 24'h000001);
        vco_pulse(1'b0);
        check(24'(locked_o), 24'h000000);
        check({det_up_o, det_down_o}, 24'h000003);
        reg_write(8'h0B, 24'h000862);
        check({det_up_o, det_down_o}, 24'h000001);
    endtask

    // unmapped place, reserved detector bits kept as written
    task automatic test_unmapped();
        logic [23:0] q;
        reg_write(8'h0B, 24'h000400);
        reg_write(8'h0C, 24'hFFFFFF);
        reg_read(8'h0C, q);
        check(q, 24'h000000);
        reg_read(8'h0B, q);
        check(q, 24'h000400);
        reg_read(8'h0A, q);
        check(q, 24'h000003);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        test_reset_values();
        test_pump_currents();
        test_bias();
        test_detector();
        test_mute_lock();
        test_unmapped();
        report_and_stop();
    end
endmodule
